// ===== include/serial_mode_regs.vh
// Register offsets, field positions and timing counts for the serial mode block
`ifndef SERIAL_MODE_REGS_VH
`define SERIAL_MODE_REGS_VH
`define ADDR_W 8
`define OFF_CTRL 8'h00
`define OFF_STATUS 8'h04
`define OFF_STRAPS 8'h08
`define OFF_TAPS 8'h0C
`define OFF_SCLK 8'h10
`define CTRL_APPLY 0
`define CTRL_RATE16 1
`define CTRL_PENDING 2
`define CLK_KHZ 40000
`define SCLK_KHZ 2048
`define ACC_STEP (2 * `SCLK_KHZ)
`define BITS_PER_FRAME 256
`define LONG_SYNC_BITS 8
`define IDLE_NS 25600
`define IDLE_CYCLES ((`IDLE_NS * `CLK_KHZ) / 1000000)
`define CFG_SETTLE 3'h5
`define TAPS_TOTAL 10'h200
`define TAPS_NETWORK 10'h0A0
`define MODE_NONE 3'h0
`define MODE_CODEC 3'h1
`define MODE_DSP 3'h2
`define MODE_CASCADE 3'h3
`define MODE_DSP_CASCADE 3'h4
`define MODE_NET_SINGLE 3'h5
`define MODE_NET_DUAL 3'h6
`define P2048_LO 8'h12
`define P2048_HI 8'h16
`define P1024_LO 8'h25
`define P1024_HI 8'h29
`define P384_LO 8'h66
`define P384_HI 8'h6A
`define P256_LO 8'h9A
`define P256_HI 8'h9E
`endif

// ===== core/pin_sync.v
// Three-stage pin synchroniser, output follows once stages two and three agree
`timescale 1ns/1ps
module pin_sync #(
    parameter W = 1
) (
    input wire pclk, // System clock
    input wire presetn, // Async reset, active low
    input wire [W-1:0] pin, // Raw asynchronous inputs
    output wire [W-1:0] level // Filtered synchronous levels
);
    reg [W-1:0] s1;
    reg [W-1:0] s2;
    reg [W-1:0] s3;
    reg [W-1:0] q;
    genvar i;
    // One chain per bit; first stage feeds only the second
    generate
        for (i = 0; i < W; i = i + 1) begin : g_bit
            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    s1[i] <= 1'b0;
                    s2[i] <= 1'b0;
                    s3[i] <= 1'b0;
                    q[i] <= 1'b0;
                end else begin
                    s1[i] <= pin[i];
                    s2[i] <= s1[i];
                    s3[i] <= s2[i];
                    if (s2[i] == s3[i]) begin
                        q[i] <= s3[i];
                    end
                end
            end
        end
    endgenerate
    assign level = q;
endmodule // pin_sync

// ===== core/serial_mode_config.v
// Strap decode, timing role and serial clock handling of the echo canceller port
//
// How it works
// - Straps on pins select one of six modes
// - Pattern 0x1001 gives codec mode, short/long
// - Pattern 000011 gives external DSP mode
// - Cascade master 101010, cascade slave 100011
// - DSP cascade slave x00010, codec used when high
// - 01 0 0 m l: single port network
// - Dual port network: same, high strap set
// - Master timing from own oscillator
// - Slave timing locked to incoming bit clock
// - Master drives bit clock only at 2.048 MHz
// - Slave accepts 256k, 384k, 1.024M, 2.048M
// - 512 taps, 64 ms at 8 kHz; codec mode keeps 160 for network, 44 ms
// - At 16 kHz span drops to 32 ms
// - Network modes may split into two channels
// - Two channels: shared bus or one each
// - Bypass mic gain for line-level input
// - Cascade chains both cancellers
// - DSP cascade, codec bypassed: far end arrives digitally
// - 16-bit DSP modes: top bit steers control
// - Codec mode: own sync, 8-bit, no control
`timescale 1ns/1ps
`include "serial_mode_regs.vh"
module serial_mode_config (
    input wire pclk, // 40 MHz system clock
    input wire presetn, // Async reset, active low
    input wire psel, // APB select
    input wire penable, // APB enable
    input wire pwrite, // APB direction
    input wire [`ADDR_W-1:0] paddr, // APB byte address
    input wire [31:0] pwdata, // APB write data
    output wire [31:0] prdata, // APB read data
    output wire pready, // APB ready
    output wire pslverr, // APB error
    input wire codec_use_select, // Strap: on-chip codec used
    input wire frame_length_select, // Strap: long frame / network
    input wire serial_timing_master_select, // Strap: timing master
    input wire mode_strap_high, // Strap high
    input wire mode_strap_mid, // Strap mid
    input wire mode_strap_low, // Strap low
    input wire sclk_in, // Serial bit clock pin in
    output reg sclk_out, // Serial bit clock pin out
    output wire sclk_oe, // Serial bit clock drive enable
    input wire serial_frame_sync_in, // Frame sync pin in
    output reg serial_frame_sync_out, // Frame sync pin out
    output wire serial_frame_sync_oe, // Frame sync drive enable
    output reg frame_start, // Frame begins, one-cycle pulse
    output reg [2:0] mode, // Active mode code
    output reg mode_unsupported, // Strap pattern not listed
    output reg timing_master, // Device owns serial timing
    output reg pll_ref_sclk, // Internal timing from bit clock
    output reg frame_long, // Long frame sync
    output reg word16, // 16-bit words, else 8-bit
    output reg two_channel, // Taps split in two channels
    output reg dual_port, // One serial bus per channel
    output reg cascade_chain, // Filters chained across chips
    output reg far_end_digital, // Far end from serial data
    output reg mic_gain_bypass, // 26 dB stage bypassed
    output reg control_enable, // Steering flag honoured
    output reg sclk_rate_ok // Slave bit clock rate valid
);
    wire [5:0] strap_sync;
    wire sclk_s;
    wire fsync_s;
    reg sclk_d;
    reg fsync_d;
    reg loaded;
    reg pending;
    reg rate16;
    reg [5:0] straps;
    reg [5:0] cfg;
    reg [2:0] next_mode;
    reg [2:0] settle;
    reg [16:0] acc;
    reg [7:0] bit_cnt;
    reg [7:0] per_cnt;
    reg [7:0] period;
    reg [2:0] rate_code;
    reg [15:0] idle_cnt;
    reg [9:0] acoustic_taps;
    reg [9:0] network_taps;
    reg [9:0] taps_per_ch;
    reg [7:0] span_ms;
    reg [31:0] rdata;
    reg err;
    wire sclk_rise;
    wire fsync_rise;
    wire link_idle;
    wire gen_rise;
    wire frame_end;
    wire take_cfg;
    wire apb_wr;
    wire [16:0] acc_sum;
    localparam [31:0] STEP_W = `ACC_STEP;
    localparam [31:0] WRAP_W = `CLK_KHZ;
    localparam [31:0] LSYNC_W = `LONG_SYNC_BITS;

    // Straps and link pins enter through three-stage synchronisers
    pin_sync #(.W(6)) u_strap_sync (
        .pclk(pclk),
        .presetn(presetn),
        .pin({codec_use_select, frame_length_select, serial_timing_master_select,
              mode_strap_high, mode_strap_mid, mode_strap_low}),
        .level(strap_sync)
    );
    pin_sync #(.W(2)) u_link_sync (
        .pclk(pclk),
        .presetn(presetn),
        .pin({sclk_in, serial_frame_sync_in}),
        .level({sclk_s, fsync_s})
    );

    // Edge finders on filtered link levels
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sclk_d <= 1'b0;
            fsync_d <= 1'b0;
        end else begin
            sclk_d <= sclk_s;
            fsync_d <= fsync_s;
        end
    end
    assign sclk_rise = sclk_s & ~sclk_d;
    assign fsync_rise = fsync_s & ~fsync_d;

    // Strap pattern to mode, listed patterns only, others give none
    always @* begin
        casez (straps)
            6'b0?1001: next_mode = `MODE_CODEC;
            6'b000011: next_mode = `MODE_DSP;
            6'b101010: next_mode = `MODE_CASCADE;
            6'b100011: next_mode = `MODE_CASCADE;
            6'b?00010: next_mode = `MODE_DSP_CASCADE;
            6'b01000?: next_mode = `MODE_NET_SINGLE;
            6'b01001?: next_mode = `MODE_NET_SINGLE;
            6'b01010?: next_mode = `MODE_NET_DUAL;
            6'b01011?: next_mode = `MODE_NET_DUAL;
            default: next_mode = `MODE_NONE;
        endcase
    end

    // Link idle after a quiet spell with no bit clock edge
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            idle_cnt <= 16'h0000;
        end else if (sclk_rise) begin
            idle_cnt <= 16'h0000;
        end else if (idle_cnt != `IDLE_CYCLES) begin
            idle_cnt <= idle_cnt + 16'h0001;
        end
    end
    assign link_idle = (idle_cnt == `IDLE_CYCLES);

    // Straps taken once after reset, later only on apply at a safe point
    assign frame_end = timing_master ? (gen_rise && bit_cnt == 8'hFF) : link_idle;
    assign take_cfg = (!loaded && settle == `CFG_SETTLE) || (pending && frame_end);
    // First capture waits until the strap synchronisers hold the pin levels
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            settle <= 3'h0;
        end else if (settle != `CFG_SETTLE) begin
            settle <= settle + 3'h1;
        end
    end
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            loaded <= 1'b0;
            straps <= 6'h00;
            cfg <= 6'h00;
        end else begin
            straps <= strap_sync;
            if (take_cfg) begin
                loaded <= 1'b1;
                cfg <= straps;
            end
        end
    end

    // Decoded configuration exported to the serial logic
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode <= `MODE_NONE;
            mode_unsupported <= 1'b0;
            timing_master <= 1'b0;
            pll_ref_sclk <= 1'b1;
            frame_long <= 1'b0;
            word16 <= 1'b0;
            two_channel <= 1'b0;
            dual_port <= 1'b0;
            cascade_chain <= 1'b0;
            far_end_digital <= 1'b0;
            mic_gain_bypass <= 1'b0;
            control_enable <= 1'b0;
        end else if (take_cfg) begin
            mode <= next_mode;
            mode_unsupported <= (next_mode == `MODE_NONE);
            timing_master <= straps[3] && next_mode != `MODE_NONE;
            pll_ref_sclk <= !(straps[3] && next_mode != `MODE_NONE);
            frame_long <= straps[4] && next_mode == `MODE_CODEC;
            // Codec mode carries 8-bit companded words; network width from mid strap
            case (next_mode)
                `MODE_CODEC: word16 <= 1'b0;
                `MODE_NET_SINGLE, `MODE_NET_DUAL: word16 <= straps[1];
                `MODE_NONE: word16 <= 1'b0;
                default: word16 <= 1'b1;
            endcase
            two_channel <= (next_mode == `MODE_NET_SINGLE || next_mode == `MODE_NET_DUAL)
                && !straps[0];
            dual_port <= (next_mode == `MODE_NET_DUAL);
            cascade_chain <= (next_mode == `MODE_CASCADE ||
                next_mode == `MODE_DSP_CASCADE);
            far_end_digital <= (next_mode == `MODE_DSP_CASCADE) && !straps[5];
            // Master chip of analog cascade takes line level on its converter
            mic_gain_bypass <= (next_mode == `MODE_CASCADE) && straps[3];
            // Steering flag only in DSP-facing 16-bit modes
            control_enable <= (next_mode == `MODE_DSP ||
                next_mode == `MODE_DSP_CASCADE);
        end
    end

    // Tap allocation and echo span per channel
    always @* begin
        if (mode == `MODE_CODEC) begin
            network_taps = `TAPS_NETWORK;
        end else begin
            network_taps = 10'h000;
        end
        acoustic_taps = `TAPS_TOTAL - network_taps;
        taps_per_ch = two_channel ? {1'b0, acoustic_taps[9:1]} : acoustic_taps;
        span_ms = rate16 ? {2'b00, taps_per_ch[9:4]} : {1'b0, taps_per_ch[9:3]};
    end

    // Own 2.048 MHz bit clock by phase accumulation
    assign acc_sum = acc + STEP_W[16:0];
    assign gen_rise = (acc_sum >= WRAP_W[16:0]) && !sclk_out;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc <= 17'h0_0000;
            sclk_out <= 1'b0;
        end else if (!timing_master) begin
            acc <= 17'h0_0000;
            sclk_out <= 1'b0;
        end else if (acc_sum >= WRAP_W[16:0]) begin
            acc <= acc_sum - WRAP_W[16:0];
            sclk_out <= !sclk_out;
        end else begin
            acc <= acc_sum;
        end
    end
    assign sclk_oe = timing_master;

    // Bit counter and frame sync as master; follow incoming sync as slave
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bit_cnt <= 8'h00;
            serial_frame_sync_out <= 1'b0;
            frame_start <= 1'b0;
        end else if (timing_master) begin
            frame_start <= gen_rise && bit_cnt == 8'hFF;
            if (gen_rise) begin
                bit_cnt <= bit_cnt + 8'h01;
                if (frame_long) begin
                    serial_frame_sync_out <= (bit_cnt + 8'h01) < LSYNC_W[7:0];
                end else begin
                    serial_frame_sync_out <= (bit_cnt == 8'hFE);
                end
            end
        end else begin
            bit_cnt <= 8'h00;
            serial_frame_sync_out <= 1'b0;
            // Frame start taken at the rise of the incoming sync pulse
            frame_start <= fsync_rise;
        end
    end
    assign serial_frame_sync_oe = timing_master;

    // Incoming bit clock period, measured in system cycles
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            per_cnt <= 8'h00;
            period <= 8'h00;
        end else if (sclk_rise) begin
            per_cnt <= 8'h01;
            period <= per_cnt;
        end else if (per_cnt != 8'hFF) begin
            per_cnt <= per_cnt + 8'h01;
        end
    end

    // Rate class of the slave bit clock
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rate_code <= 3'h0;
            sclk_rate_ok <= 1'b0;
        end else if (link_idle) begin
            rate_code <= 3'h0;
            sclk_rate_ok <= 1'b0;
        end else begin
            if (period >= `P2048_LO && period <= `P2048_HI) begin
                rate_code <= 3'h4;
            end else if (period >= `P1024_LO && period <= `P1024_HI) begin
                rate_code <= 3'h3;
            end else if (period >= `P384_LO && period <= `P384_HI) begin
                rate_code <= 3'h2;
            end else if (period >= `P256_LO && period <= `P256_HI) begin
                rate_code <= 3'h1;
            end else begin
                rate_code <= 3'h0;
            end
            sclk_rate_ok <= !timing_master && rate_code != 3'h0;
        end
    end

    // APB control: apply request and sample rate select
    assign apb_wr = psel && penable && pwrite;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pending <= 1'b0;
            rate16 <= 1'b0;
        end else begin
            if (apb_wr && paddr == `OFF_CTRL) begin
                rate16 <= pwdata[`CTRL_RATE16];
            end
            if (apb_wr && paddr == `OFF_CTRL && pwdata[`CTRL_APPLY]) begin
                pending <= 1'b1;
            end else if (loaded && take_cfg) begin
                pending <= 1'b0;
            end
        end
    end

    // APB read mux, unmapped addresses read zero with error
    always @* begin
        rdata = 32'h0000_0000;
        err = 1'b0;
        case (paddr)
            `OFF_CTRL: rdata = {29'h0, pending, rate16, 1'b0};
            `OFF_STATUS: rdata = {16'h0, sclk_rate_ok, rate_code, mode_unsupported,
                control_enable, mic_gain_bypass, far_end_digital, cascade_chain,
                dual_port, two_channel, word16, frame_long, timing_master, 2'b00} |
                {29'h0, mode};
            `OFF_STRAPS: rdata = {26'h0, cfg};
            `OFF_TAPS: rdata = {4'h0, span_ms, network_taps, acoustic_taps};
            `OFF_SCLK: rdata = {24'h0, period};
            default: err = 1'b1;
        endcase
    end
    assign prdata = rdata;
    assign pready = 1'b1;
    assign pslverr = psel && penable && err;
endmodule // serial_mode_config

// ===== sim/link_partner.sv
// Far-side bit clock and frame sync source for the slave modes
`timescale 1ns/1ps
module link_partner (
    input wire logic run, // Frames wanted
    output logic sclk, // Bit clock to device
    output logic fsync // Start-of-frame pulse
);
    // Back-to-back 16-bit frames, sync one bit ahead; clock still when idle
    initial begin
        sclk = 1'b0;
        fsync = 1'b0;
        forever begin
            if (run) begin
                fsync = 1'b1;
                #100 sclk = 1'b1;
                #100 sclk = 1'b0;
                fsync = 1'b0;
                repeat (16) begin
                    #100 sclk = 1'b1;
                    #100 sclk = 1'b0;
                end
            end else begin
                #137;
            end
        end
    end
endmodule // link_partner

// ===== sim/serial_mode_config_chk.sv
// Assertions on strap decode, timing role and frame timing
`timescale 1ns/1ps
`include "serial_mode_regs.vh"
module serial_mode_config_chk (
    input wire logic pclk, // System clock
    input wire logic presetn, // Reset, active low
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic [`ADDR_W-1:0] paddr, // APB address
    input wire logic pslverr, // APB error
    input wire logic sclk_out, // Bit clock out
    input wire logic sclk_oe, // Bit clock enable
    input wire logic serial_frame_sync_in, // Sync pin in
    input wire logic serial_frame_sync_oe, // Sync enable
    input wire logic frame_start, // Frame pulse
    input wire logic [2:0] mode, // Mode code
    input wire logic mode_unsupported, // Unlisted pattern
    input wire logic timing_master, // Timing owner
    input wire logic pll_ref_sclk, // Timing from bit clock
    input wire logic word16, // Word width
    input wire logic control_enable, // Steering honoured
    input wire logic dual_port // Bus per channel
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic [12:0] gap;
    logic seen;
    // Cycles since the last frame pulse
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gap <= 13'h0000;
            seen <= 1'b0;
        end else if (frame_start) begin
            gap <= 13'h0000;
            seen <= timing_master;
        end else begin
            gap <= gap + 13'h0001;
        end
    end
    sequence s_quiet;
        (!$changed(sclk_out)) [*8];
    endsequence
    sequence s_toggle;
        ##[1:2] $changed(sclk_out);
    endsequence
    property p_oe;
        sclk_oe == timing_master && serial_frame_sync_oe == timing_master &&
            (!timing_master || mode == `MODE_CODEC || mode == `MODE_CASCADE);
    endproperty
    a_oe: assert property (p_oe) else $error("drive enable differs from role");
    property p_pll;
        pll_ref_sclk == !timing_master;
    endproperty
    a_pll: assert property (p_pll) else $error("pll reference wrong");
    property p_unsup;
        mode_unsupported |-> mode == `MODE_NONE && pll_ref_sclk;
    endproperty
    a_unsup: assert property (p_unsup) else $error("unsupported with a mode");
    property p_err;
        psel && penable && paddr > 8'h10 |-> pslverr;
    endproperty
    a_err: assert property (p_err) else $error("unmapped access not refused");
    property p_pulse;
        frame_start |=> !frame_start;
    endproperty
    a_pulse: assert property (p_pulse) else $error("frame pulse too long");
    property p_sclk_rate;
        timing_master && $changed(sclk_out) |=> s_quiet ##0 s_toggle;
    endproperty
    a_sclk_rate: assert property (p_sclk_rate) else $error("bit clock half period");
    property p_slave_sync;
        !timing_master && control_enable && $rose(serial_frame_sync_in) |-> ##[4:6] frame_start;
    endproperty
    a_slave_sync: assert property (p_slave_sync) else $error("no frame after sync");
    property p_frame_len;
        frame_start && timing_master && seen |-> gap >= 13'h137E && gap <= 13'h1392;
    endproperty
    a_frame_len: assert property (p_frame_len) else $error("master frame length");
    property p_codec;
        mode == `MODE_CODEC |-> timing_master && !word16 && !control_enable;
    endproperty
    a_codec: assert property (p_codec) else $error("codec mode decode");
    property p_net;
        mode >= `MODE_NET_SINGLE |-> !timing_master && dual_port == (mode == `MODE_NET_DUAL);
    endproperty
    a_net: assert property (p_net) else $error("network mode decode");
endmodule // serial_mode_config_chk

bind serial_mode_config serial_mode_config_chk i_chk (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .paddr(paddr), .pslverr(pslverr), .sclk_out(sclk_out),
    .sclk_oe(sclk_oe), .serial_frame_sync_in(serial_frame_sync_in),
    .serial_frame_sync_oe(serial_frame_sync_oe), .frame_start(frame_start), .mode(mode),
    .mode_unsupported(mode_unsupported), .timing_master(timing_master),
    .pll_ref_sclk(pll_ref_sclk), .word16(word16), .control_enable(control_enable),
    .dual_port(dual_port));

// ===== sim/tb.sv
// Self-checking bench for the strap decode and serial timing block
`timescale 1ns/1ps
`include "serial_mode_regs.vh"
module tb;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [5:0] st = 6'h00;
    logic run = 1'b0;
    logic [31:0] rd;
    logic err, tm;
    logic [5:0] s;
    logic [2:0] m;
    integer err_total = 0;
    integer tests_run = 0;
    integer cyc = 0;
    integer seed = 32'h38cb;
    integer i, n, f_dev, f_far, tog;
    wire [31:0] prdata;
    wire [2:0] mode;
    wire pready, pslverr, sclk_out, sclk_oe, fs_out, fs_oe, frame_start, mode_unsupported;
    wire timing_master, pll_ref_sclk, frame_long, word16, two_channel, dual_port, p_sclk;
    wire cascade_chain, far_end_digital, mic_gain_bypass, control_enable, sclk_rate_ok, p_fs;
    wire sclk_pin = sclk_oe ? sclk_out : p_sclk;
    wire fs_pin = fs_oe ? fs_out : p_fs;
    serial_mode_config i_serial_mode_config (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .codec_use_select(st[5]),
        .frame_length_select(st[4]), .serial_timing_master_select(st[3]),
        .mode_strap_high(st[2]), .mode_strap_mid(st[1]), .mode_strap_low(st[0]),
        .sclk_in(sclk_pin), .sclk_out(sclk_out), .sclk_oe(sclk_oe),
        .serial_frame_sync_in(fs_pin), .serial_frame_sync_out(fs_out),
        .serial_frame_sync_oe(fs_oe), .frame_start(frame_start), .mode(mode),
        .mode_unsupported(mode_unsupported), .timing_master(timing_master),
        .pll_ref_sclk(pll_ref_sclk), .frame_long(frame_long), .word16(word16),
        .two_channel(two_channel), .dual_port(dual_port), .cascade_chain(cascade_chain),
        .far_end_digital(far_end_digital), .mic_gain_bypass(mic_gain_bypass),
        .control_enable(control_enable), .sclk_rate_ok(sclk_rate_ok));
    link_partner i_link_partner (.run(run && !sclk_oe), .sclk(p_sclk), .fsync(p_fs));
    // Clock, timeout and event counters
    always #12.5 pclk = ~pclk;
    always @(sclk_out) tog = tog + 1;
    always @(posedge fs_pin) f_far = f_far + 1;
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (frame_start === 1'b1) f_dev = f_dev + 1;
        if (cyc == 40000) begin
            err_total = err_total + 1;
            final_report;
        end
    end
    // Expected mode of a strap pattern
    function automatic logic [2:0] exp_mode(input logic [5:0] v);
        casez (v)
            6'b0?1001: exp_mode = `MODE_CODEC;
            6'b000011: exp_mode = `MODE_DSP;
            6'b101010, 6'b100011: exp_mode = `MODE_CASCADE;
            6'b?00010: exp_mode = `MODE_DSP_CASCADE;
            6'b0100??: exp_mode = `MODE_NET_SINGLE;
            6'b0101??: exp_mode = `MODE_NET_DUAL;
            default: exp_mode = `MODE_NONE;
        endcase
    endfunction
    task final_report;
        begin
            $display("comparisons %0d mismatches %0d", tests_run, err_total);
            if (err_total == 0 && tests_run > 0) begin
                $display("bench passed");
            end else begin
                $display("bench failed");
            end
            $finish;
        end
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        begin
            tests_run = tests_run + 1;
            if (got !== exp) begin
                err_total = err_total + 1;
                $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
            end
        end
    endtask
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        begin
            @(posedge pclk);
            psel <= 1'b1;
            pwrite <= wr;
            paddr <= a;
            pwdata <= d;
            @(posedge pclk);
            penable <= 1'b1;
            @(posedge pclk);
            while (pready !== 1'b1) begin
                @(posedge pclk);
            end
            rd = prdata;
            err = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask
    task boot(input logic [5:0] v);
        begin
            @(posedge pclk);
            presetn <= 1'b0;
            st <= v;
            repeat (4) @(posedge pclk);
            presetn <= 1'b1;
            repeat (8) @(posedge pclk);
        end
    endtask
    initial begin
        repeat (3) @(posedge pclk);
        chk(pll_ref_sclk, 1'b1, "pll ref in reset");
        s = $random(seed);
        for (i = 0; i < 64; i = i + 1) begin
            s = s + 6'h01;
            boot(s);
            m = exp_mode(s);
            tm = s == 6'h09 || s == 6'h19 || s == 6'h2A;
            chk(mode, m, "mode");
            chk(mode_unsupported, m == `MODE_NONE, "unsupported");
            chk(timing_master, tm, "master");
            chk(sclk_oe, tm, "clock drive");
            chk(pll_ref_sclk, !tm, "pll ref");
            chk(frame_long, m == `MODE_CODEC && s[4], "long frame");
            chk(control_enable, m == `MODE_DSP || m == `MODE_DSP_CASCADE, "steer");
            chk(far_end_digital, s == 6'h02, "far end");
            chk(mic_gain_bypass, s == 6'h2A, "mic bypass");
            chk(dual_port, m == `MODE_NET_DUAL, "dual port");
            if (m != `MODE_DSP_CASCADE) chk(cascade_chain, m == `MODE_CASCADE, "chain");
            if (m >= `MODE_NET_SINGLE) begin
                chk(word16, s[1], "width");
                chk(two_channel, !s[0], "channels");
            end else if (m == `MODE_CODEC) chk(word16, 1'b0, "codec width");
        end
        $display("test decode done");
        boot(6'h10);
        apb(1'b0, `OFF_TAPS, 32'h0000_0000);
        chk(rd[27:20], 8'h20, "split span");
        boot(6'h03);
        run <= 1'b1;
        apb(1'b0, `OFF_STRAPS, 32'h0000_0000);
        chk(rd[5:0], 6'h03, "straps");
        apb(1'b0, `OFF_TAPS, 32'h0000_0000);
        chk(rd[9:0], `TAPS_TOTAL, "taps");
        chk(rd[27:20], 8'h40, "span");
        n = $random(seed);
        apb(1'b1, `OFF_CTRL, {n[31:3], 3'b010});
        apb(1'b0, `OFF_CTRL, 32'h0000_0000);
        chk(rd[2:0], 3'b010, "ctrl");
        apb(1'b0, `OFF_TAPS, 32'h0000_0000);
        chk(rd[27:20], 8'h20, "span at 16k");
        apb(1'b0, 8'h20, 32'h0000_0000);
        chk(err, 1'b1, "unmapped error");
        chk(rd, 32'h0000_0000, "unmapped data");
        f_dev = 0;
        f_far = 0;
        repeat (2000) @(posedge pclk);
        chk(f_dev > 5 && f_dev - f_far <= 1 && f_far - f_dev <= 1, 1'b1, "frames");
        apb(1'b0, `OFF_SCLK, 32'h0000_0000);
        chk(rd[7:0] >= 8'h07 && rd[7:0] <= 8'h09, 1'b1, "period");
        chk(sclk_rate_ok, 1'b0, "rate illegal");
        run <= 1'b0;
        $display("test slave done");
        boot(6'h09);
        tog = 0;
        f_far = 0;
        repeat (5000) @(posedge pclk);
        chk(tog >= 510 && tog <= 514, 1'b1, "bit clock rate");
        chk(f_far, 1, "sync pulses");
        st <= 6'h2A;
        repeat (6000) @(posedge pclk);
        chk(mode, `MODE_CODEC, "no switch");
        apb(1'b1, `OFF_CTRL, 32'h0000_0001);
        apb(1'b0, `OFF_CTRL, 32'h0000_0000);
        chk(rd[2], 1'b1, "pending");
        n = 0;
        while (mode !== `MODE_CASCADE && n < 6000) begin
            @(posedge pclk);
            n = n + 1;
        end
        chk(mode, `MODE_CASCADE, "applied");
        chk(mic_gain_bypass, 1'b1, "mic bypass");
        apb(1'b0, `OFF_CTRL, 32'h0000_0000);
        chk(rd[2], 1'b0, "pending cleared");
        $display("test master done");
        final_report;
    end
endmodule // tb
